// >>> src/pdo_pkg.sv
// package: register map, field positions and carriers for the port block
package pdo_pkg;
  localparam int unsigned PDO_AW = 8;
  localparam int unsigned PDO_DW = 32;
  localparam logic [7:0] PDO_OFS_PB_LATCH = 8'h00;
  localparam logic [7:0] PDO_OFS_PB_DIR   = 8'h04;
  localparam logic [7:0] PDO_OFS_PB_LVL   = 8'h08;
  localparam logic [7:0] PDO_OFS_PC_LATCH = 8'h0c;
  localparam logic [7:0] PDO_OFS_PC_DIR   = 8'h10;
  localparam logic [7:0] PDO_OFS_PD_LATCH = 8'h14;
  localparam logic [7:0] PDO_OFS_PD_DIR   = 8'h18;
  localparam logic [7:0] PDO_OFS_PD_LVL   = 8'h1c;
  localparam logic [7:0] PDO_OFS_CTRL     = 8'h20;
  localparam logic [7:0] PDO_OFS_PC_MASK  = 8'h24;
  localparam logic [7:0] PDO_OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] PDO_OFS_IRQ_MASK = 8'h2c;
  localparam logic [7:0] PDO_RST_BYTE     = 8'h00;
  localparam logic [7:0] PDO_PC_WMASK     = 8'h7f;
  localparam logic [2:0] PDO_RST_CTRL     = 3'h0;
  localparam int unsigned PDO_CTL_PUD  = 0;
  localparam int unsigned PDO_CTL_PCG1 = 1;
  localparam int unsigned PDO_CTL_PCG2 = 2;
  localparam int unsigned PDO_IRQ_PCG2 = 0;
  localparam int unsigned PDO_PIN_RX   = 0;
  localparam int unsigned PDO_PIN_TX   = 1;
  localparam int unsigned PDO_PIN_X0   = 2;
  localparam int unsigned PDO_PIN_X1   = 3;
  localparam int unsigned PDO_PIN_SCK  = 4;
  localparam int unsigned PDO_PIN_T0B  = 5;
  localparam int unsigned PDO_PIN_T0A  = 6;

  typedef struct packed {
    logic pu_en;
    logic pu_val;
    logic dir_en;
    logic dir_val;
    logic val_en;
    logic val_val;
    logic die_en;
    logic die_val;
  } pdo_ovr_t;

  typedef struct packed {
    logic receiver_on;
    logic transmitter_on;
    logic tx_data;
    logic serial_sync_mode_select;
    logic serial_sync_clock;
    logic timer0_cmp_a_en;
    logic timer0_cmp_a_out;
    logic timer0_cmp_b_en;
    logic timer0_cmp_b_out;
    logic timer2_cmp_b_en;
    logic timer2_cmp_b_out;
    logic ext_irq_0_en;
    logic ext_irq_1_en;
  } pdo_periph_t;
endpackage

// >>> src/pdo_pin_mux.sv
// pad control: override selection over register-derived pin controls
`timescale 1ns/1ps
module pdo_pin_mux import pdo_pkg::*; #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0]     latch,
  input  wire logic [N-1:0]     dir,
  input  wire logic             pullup_global_disable,
  input  wire logic             sleep_active,
  input  wire pdo_ovr_t [N-1:0] ovr,
  output logic [N-1:0]          pad_out,
  output logic [N-1:0]          pad_oe,
  output logic [N-1:0]          pad_pullup,
  output logic [N-1:0]          pad_die
);
  for (genvar i = 0; i < N; i++) begin : g_pin
    assign pad_pullup[i] = ovr[i].pu_en  ? ovr[i].pu_val  : (latch[i] & ~dir[i] & ~pullup_global_disable);
    assign pad_oe[i]     = ovr[i].dir_en ? ovr[i].dir_val : dir[i];
    assign pad_out[i]    = ovr[i].val_en ? ovr[i].val_val : latch[i];
    assign pad_die[i]    = ovr[i].die_en ? ovr[i].die_val : ~sleep_active;
  end
endmodule

// >>> src/pdo_pin_change.sv
// pin change detector: one pulse when any enabled sampled level toggles
`timescale 1ns/1ps
module pdo_pin_change #(
  parameter int unsigned N = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] level,
  input  wire logic [N-1:0] mask,
  input  wire logic         group_en,
  output logic              evt
);
  logic [N-1:0] prev_q;
  logic         evt_q;
  wire          hit = group_en & (|((level ^ prev_q) & mask));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      evt_q  <= 1'b0;
    end else begin
      prev_q <= level;
      evt_q  <= hit;
    end
  end

  assign evt = evt_q;
endmodule

// >>> src/pdo_port_top.sv
// port b/c/d pin logic with port d alternate-function overrides, apb registers
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module pdo_port_top import pdo_pkg::*; (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [PDO_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [PDO_DW-1:0] pwdata,
  output logic [PDO_DW-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire pdo_periph_t       periph,
  input  wire logic              sleep_active,
  input  wire logic [7:0]        pb_in,
  output logic [7:0]             pb_out,
  output logic [7:0]             pb_oe,
  output logic [7:0]             pb_pullup,
  output logic [7:0]             pb_die,
  input  wire logic [6:0]        pc_in,
  output logic [6:0]             pc_out,
  output logic [6:0]             pc_oe,
  output logic [6:0]             pc_pullup,
  output logic [6:0]             pc_die,
  input  wire logic [7:0]        pd_in,
  output logic [7:0]             pd_out,
  output logic [7:0]             pd_oe,
  output logic [7:0]             pd_pullup,
  output logic [7:0]             pd_die,
  output logic                   rx_data,
  output logic                   pin_change_src_16,
  output logic                   pin_change_group2_irq,
  output logic                   irq
);
  function automatic logic is_reg(input logic [PDO_AW-1:0] a, input logic [PDO_AW-1:0] ofs);
    is_reg = (a == ofs);
  endfunction

  logic [7:0] pb_latch_q;
  logic [7:0] pb_dir_q;
  logic [7:0] pb_lvl_q;
  logic [6:0] pc_latch_q;
  logic [6:0] pc_dir_q;
  logic [7:0] pd_latch_q;
  logic [7:0] pd_dir_q;
  logic [7:0] pd_lvl_q;
  logic [2:0] ctrl_q;
  logic [7:0] pcmsk_q;
  logic       stat_q;
  logic       stat_d;
  logic       imask_q;
  logic [PDO_DW-1:0] rdata_q;
  logic       pcg2_evt;

  // bus decode
  wire wr_en     = psel & penable & pwrite;
  wire setup_rd  = psel & ~penable & ~pwrite;
  wire w_pb_lat  = wr_en & is_reg(paddr, PDO_OFS_PB_LATCH);
  wire w_pb_dir  = wr_en & is_reg(paddr, PDO_OFS_PB_DIR);
  wire w_pc_lat  = wr_en & is_reg(paddr, PDO_OFS_PC_LATCH);
  wire w_pc_dir  = wr_en & is_reg(paddr, PDO_OFS_PC_DIR);
  wire w_pd_lat  = wr_en & is_reg(paddr, PDO_OFS_PD_LATCH);
  wire w_pd_dir  = wr_en & is_reg(paddr, PDO_OFS_PD_DIR);
  wire w_ctrl    = wr_en & is_reg(paddr, PDO_OFS_CTRL);
  wire w_pcmsk   = wr_en & is_reg(paddr, PDO_OFS_PC_MASK);
  wire w_stat    = wr_en & is_reg(paddr, PDO_OFS_IRQ_STAT);
  wire w_imask   = wr_en & is_reg(paddr, PDO_OFS_IRQ_MASK);
  wire pullup_global_disable       = ctrl_q[PDO_CTL_PUD];
  wire pcg1_en   = ctrl_q[PDO_CTL_PCG1];
  wire pcg2_en   = ctrl_q[PDO_CTL_PCG2];
  wire addr_hit  = is_reg(paddr, PDO_OFS_PB_LATCH) | is_reg(paddr, PDO_OFS_PB_DIR)
                 | is_reg(paddr, PDO_OFS_PB_LVL)   | is_reg(paddr, PDO_OFS_PC_LATCH)
                 | is_reg(paddr, PDO_OFS_PC_DIR)   | is_reg(paddr, PDO_OFS_PD_LATCH)
                 | is_reg(paddr, PDO_OFS_PD_DIR)   | is_reg(paddr, PDO_OFS_PD_LVL)
                 | is_reg(paddr, PDO_OFS_CTRL)     | is_reg(paddr, PDO_OFS_PC_MASK)
                 | is_reg(paddr, PDO_OFS_IRQ_STAT) | is_reg(paddr, PDO_OFS_IRQ_MASK);

  // read selection, bit 7 of port c registers reads zero
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr)
      PDO_OFS_PB_LATCH: rd_byte = pb_latch_q;
      PDO_OFS_PB_DIR:   rd_byte = pb_dir_q;
      PDO_OFS_PB_LVL:   rd_byte = pb_lvl_q;
      PDO_OFS_PC_LATCH: rd_byte = {1'b0, pc_latch_q};
      PDO_OFS_PC_DIR:   rd_byte = {1'b0, pc_dir_q};
      PDO_OFS_PD_LATCH: rd_byte = pd_latch_q;
      PDO_OFS_PD_DIR:   rd_byte = pd_dir_q;
      PDO_OFS_PD_LVL:   rd_byte = pd_lvl_q;
      PDO_OFS_CTRL:     rd_byte = {5'h00, ctrl_q};
      PDO_OFS_PC_MASK:  rd_byte = pcmsk_q;
      PDO_OFS_IRQ_STAT: rd_byte = {7'h00, stat_q};
      PDO_OFS_IRQ_MASK: rd_byte = {7'h00, imask_q};
      default:          rd_byte = 8'h00;
    endcase
  end

  // port d override signals
  pdo_ovr_t [7:0] pd_ovr;
  always_comb begin
    pd_ovr = '0;
    pd_ovr[PDO_PIN_RX].pu_en   = periph.receiver_on;
    pd_ovr[PDO_PIN_RX].pu_val  = pd_latch_q[PDO_PIN_RX] & ~pullup_global_disable;
    pd_ovr[PDO_PIN_RX].dir_en  = periph.receiver_on;
    pd_ovr[PDO_PIN_RX].dir_val = 1'b0;
    pd_ovr[PDO_PIN_TX].pu_en   = periph.transmitter_on;
    pd_ovr[PDO_PIN_TX].pu_val  = 1'b0;
    pd_ovr[PDO_PIN_TX].dir_en  = periph.transmitter_on;
    pd_ovr[PDO_PIN_TX].dir_val = 1'b1;
    pd_ovr[PDO_PIN_TX].val_en  = periph.transmitter_on;
    pd_ovr[PDO_PIN_TX].val_val = periph.tx_data;
    pd_ovr[PDO_PIN_X1].val_en  = periph.timer2_cmp_b_en;
    pd_ovr[PDO_PIN_X1].val_val = periph.timer2_cmp_b_out;
    pd_ovr[PDO_PIN_SCK].val_en  = periph.serial_sync_mode_select;
    pd_ovr[PDO_PIN_SCK].val_val = periph.serial_sync_clock;
    pd_ovr[PDO_PIN_T0B].val_en  = periph.timer0_cmp_b_en;
    pd_ovr[PDO_PIN_T0B].val_val = periph.timer0_cmp_b_out;
    pd_ovr[PDO_PIN_T0A].val_en  = periph.timer0_cmp_a_en;
    pd_ovr[PDO_PIN_T0A].val_val = periph.timer0_cmp_a_out;
    for (int i = 0; i < 8; i++) begin
      pd_ovr[i].die_en  = pcmsk_q[i] & pcg2_en;
      pd_ovr[i].die_val = 1'b1;
    end
    pd_ovr[PDO_PIN_X0].die_en = periph.ext_irq_0_en | (pcmsk_q[PDO_PIN_X0] & pcg1_en);
    pd_ovr[PDO_PIN_X1].die_en = periph.ext_irq_1_en | (pcmsk_q[PDO_PIN_X1] & pcg2_en);
  end

  // port d pads; ports b and c carry no overrides here
  pdo_pin_mux #(.N(8)) u_pd_mux (
    .latch        (pd_latch_q),
    .dir          (pd_dir_q),
    .pullup_global_disable          (pullup_global_disable),
    .sleep_active (sleep_active),
    .ovr          (pd_ovr),
    .pad_out      (pd_out),
    .pad_oe       (pd_oe),
    .pad_pullup   (pd_pullup),
    .pad_die      (pd_die)
  );

  pdo_pin_mux #(.N(8)) u_pb_mux (
    .latch        (pb_latch_q),
    .dir          (pb_dir_q),
    .pullup_global_disable          (pullup_global_disable),
    .sleep_active (sleep_active),
    .ovr          ('0),
    .pad_out      (pb_out),
    .pad_oe       (pb_oe),
    .pad_pullup   (pb_pullup),
    .pad_die      (pb_die)
  );

  pdo_pin_mux #(.N(7)) u_pc_mux (
    .latch        (pc_latch_q),
    .dir          (pc_dir_q),
    .pullup_global_disable          (pullup_global_disable),
    .sleep_active (sleep_active),
    .ovr          ('0),
    .pad_out      (pc_out),
    .pad_oe       (pc_oe),
    .pad_pullup   (pc_pullup),
    .pad_die      (pc_die)
  );

  pdo_pin_change #(.N(8)) u_pcg2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .level    (pd_lvl_q),
    .mask     (pcmsk_q),
    .group_en (pcg2_en),
    .evt      (pcg2_evt)
  );

  // sticky status, set wins over write-one clear
  assign stat_d = pcg2_evt | (stat_q & ~(w_stat & pwdata[PDO_IRQ_PCG2]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_latch_q <= PDO_RST_BYTE;
      pb_dir_q   <= PDO_RST_BYTE;
      pc_latch_q <= PDO_RST_BYTE[6:0];
      pc_dir_q   <= PDO_RST_BYTE[6:0];
      pd_latch_q <= PDO_RST_BYTE;
      pd_dir_q   <= PDO_RST_BYTE;
      ctrl_q     <= PDO_RST_CTRL;
      pcmsk_q    <= PDO_RST_BYTE;
      imask_q    <= 1'b0;
    end else begin
      if (w_pb_lat) pb_latch_q <= pwdata[7:0];
      if (w_pb_dir) pb_dir_q <= pwdata[7:0];
      if (w_pc_lat) pc_latch_q <= pwdata[6:0] & PDO_PC_WMASK[6:0];
      if (w_pc_dir) pc_dir_q <= pwdata[6:0];
      if (w_pd_lat) pd_latch_q <= pwdata[7:0];
      if (w_pd_dir) pd_dir_q <= pwdata[7:0];
      if (w_ctrl) ctrl_q <= pwdata[2:0];
      if (w_pcmsk) pcmsk_q <= pwdata[7:0];
      if (w_imask) imask_q <= pwdata[PDO_IRQ_PCG2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_lvl_q <= PDO_RST_BYTE;
      pd_lvl_q <= PDO_RST_BYTE;
      stat_q   <= 1'b0;
      rdata_q  <= '0;
    end else begin
      pb_lvl_q <= pb_in & pb_die;
      pd_lvl_q <= pd_in & pd_die;
      stat_q   <= stat_d;
      if (setup_rd) rdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata                = rdata_q;
  assign pready                = 1'b1;
  assign pslverr               = psel & penable & ~addr_hit;
  assign rx_data               = pd_lvl_q[PDO_PIN_RX];
  assign pin_change_src_16     = pd_lvl_q[PDO_PIN_RX];
  assign pin_change_group2_irq = pcg2_evt;
  assign irq                   = stat_q & imask_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rx_input;
    periph.receiver_on |-> !pd_oe[PDO_PIN_RX];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("rx pin not forced to input");

  property p_rx_pullup;
    periph.receiver_on |-> pd_pullup[PDO_PIN_RX] == (pd_latch_q[PDO_PIN_RX] & !pullup_global_disable);
  endproperty
  a_rx_pullup: assert property (p_rx_pullup) else $error("rx pull-up wrong");

  sequence s_pd0_toggle;
    $changed(pd_lvl_q[PDO_PIN_RX]) && pcmsk_q[PDO_PIN_RX] && pcg2_en;
  endsequence
  property p_src16;
    s_pd0_toggle |-> ##1 pin_change_group2_irq ##1 stat_q;
  endproperty
  a_src16: assert property (p_src16) else $error("pin 0 change lost");

  property p_tx_drive;
    periph.transmitter_on |-> pd_oe[PDO_PIN_TX] && !pd_pullup[PDO_PIN_TX] && pd_out[PDO_PIN_TX] == periph.tx_data;
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("tx pin not driven");

  property p_t0a_drive;
    periph.timer0_cmp_a_en |-> pd_out[PDO_PIN_T0A] == periph.timer0_cmp_a_out;
  endproperty
  a_t0a_drive: assert property (p_t0a_drive) else $error("compare a not on pin 6");

  property p_die_force;
    (pcmsk_q[PDO_PIN_T0A] && pcg2_en) |-> pd_die[PDO_PIN_T0A];
  endproperty
  a_die_force: assert property (p_die_force) else $error("input buffer not forced");

  sequence s_pb_write;
    w_pb_lat ##1 !w_pb_lat;
  endsequence
  property p_pb_store;
    logic [7:0] v;
    (w_pb_lat, v = pwdata[7:0]) ##1 !w_pb_lat |-> pb_latch_q == v && pb_out == v;
  endproperty
  a_pb_store: assert property (p_pb_store) else $error("port b latch not stored");

  property p_pc_bit7;
    (setup_rd && paddr == PDO_OFS_PC_LATCH) |=> !prdata[7];
  endproperty
  a_pc_bit7: assert property (p_pc_bit7) else $error("port c bit 7 not zero");

  property p_plain_pin;
    (!periph.timer0_cmp_a_en) |-> pd_out[PDO_PIN_T0A] == pd_latch_q[PDO_PIN_T0A]
      && pd_oe[7] == pd_dir_q[7];
  endproperty
  a_plain_pin: assert property (p_plain_pin) else $error("plain pin wrong");

  property p_irq_level;
    (stat_q && imask_q) |-> irq ##1 (irq || !stat_q || !imask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not following status");

  property p_t2b_drive;
    periph.timer2_cmp_b_en |-> pd_out[PDO_PIN_X1] == periph.timer2_cmp_b_out;
  endproperty
  a_t2b_drive: assert property (p_t2b_drive) else $error("timer2 compare b not on pin 3");

  property p_sck_drive;
    periph.serial_sync_mode_select |-> pd_out[PDO_PIN_SCK] == periph.serial_sync_clock;
  endproperty
  a_sck_drive: assert property (p_sck_drive) else $error("sync clock not on pin 4");
endmodule

// >>> testbench/pdo_pad_model.sv
// pad model: resolves pin levels from pad controls and external drivers
`timescale 1ns/1ps
module pdo_pad_model #(
  parameter int unsigned N = 8
) (
  input  wire logic         pclk,
  input  wire logic [N-1:0] out,
  input  wire logic [N-1:0] oe,
  input  wire logic [N-1:0] pull_en,
  input  wire logic [N-1:0] ext_val,
  input  wire logic [N-1:0] ext_en,
  output logic [N-1:0]      lvl
);
  logic [N-1:0] float_q;
  initial float_q = '0;
  // undriven pin without pull-up wanders every cycle
  always @(posedge pclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pull_en[i]) lvl[i] = 1'b1;
      else lvl[i] = float_q[i];
    end
  end
endmodule

// >>> testbench/testbench.sv
// self-checking bench: apb registers and port d pin overrides
`timescale 1ns/1ps
module testbench import pdo_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_active;
  logic        rx_data, src16, g2irq, irq, last_err, got;
  logic [7:0]  paddr, pb_in, pb_out, pb_oe, pb_pu, pb_die, pd_in, pd_out, pd_oe, pd_pu, pd_die, eb, ed;
  logic [7:0]  eb_en, ed_en;
  logic [6:0]  pc_in, pc_out, pc_oe, pc_pu, pc_die, ec_val, ec_en;
  logic [31:0] pwdata, prdata, rdv;
  pdo_periph_t periph;
  int          err_count, checked;

  pdo_port_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph(periph), .sleep_active(sleep_active), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pullup(pb_pu), .pb_die(pb_die), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pc_pullup(pc_pu),
    .pc_die(pc_die), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pullup(pd_pu), .pd_die(pd_die),
    .rx_data(rx_data), .pin_change_src_16(src16), .pin_change_group2_irq(g2irq), .irq(irq));
  pdo_pad_model #(.N(8)) pad_b (.pclk(pclk), .out(pb_out), .oe(pb_oe), .pull_en(pb_pu), .ext_val(eb),
    .ext_en(eb_en), .lvl(pb_in));
  pdo_pad_model #(.N(7)) pad_c (.pclk(pclk), .out(pc_out), .oe(pc_oe), .pull_en(pc_pu), .ext_val(ec_val),
    .ext_en(ec_en), .lvl(pc_in));
  pdo_pad_model #(.N(8)) pad_d (.pclk(pclk), .out(pd_out), .oe(pd_oe), .pull_en(pd_pu), .ext_val(ed),
    .ext_en(ed_en), .lvl(pd_in));

  always #2.5 pclk = ~pclk;

  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      complete_run();
    end else begin
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
    // let the write settle before pads are compared
    @(negedge pclk);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv);
    chk(name, rdv, exp);
  endtask

  // watch a few cycles for the group event pulse
  task automatic watch(input logic [7:0] v);
    @(posedge pclk);
    ed <= v;
    got = 1'b0;
    repeat (6) begin
      @(negedge pclk);
      if (g2irq === 1'b1) got = 1'b1;
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    periph = '0;
    sleep_active = 1'b0;
    eb = 8'h5a;
    ed = 8'h00;
    eb_en = 8'hff;
    ed_en = 8'hff;
    ec_val = 7'h00;
    ec_en = 7'h7f;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("pb_latch_rst", PDO_OFS_PB_LATCH, 32'h0);
    rd("pb_dir_rst", PDO_OFS_PB_DIR, 32'h0);
    rd("pc_latch_rst", PDO_OFS_PC_LATCH, 32'h0);
    wr(PDO_OFS_PB_LATCH, 32'h3c);
    wr(PDO_OFS_PB_DIR, 32'h0f);
    wr(PDO_OFS_PC_LATCH, 32'hff);
    wr(PDO_OFS_PC_DIR, 32'hff);
    rd("pb_latch", PDO_OFS_PB_LATCH, 32'h3c);
    rd("pb_dir", PDO_OFS_PB_DIR, 32'h0f);
    rd("pc_latch", PDO_OFS_PC_LATCH, 32'h7f);
    rd("pc_dir", PDO_OFS_PC_DIR, 32'h7f);
    chk("pc_pads", 32'({pc_oe, pc_out, pc_pu, pc_die}), 32'({7'h7f, 7'h7f, 7'h00, 7'h7f}));
    chk("pb_oe", 32'(pb_oe), 32'h0f);
    chk("pb_drive", 32'(pb_out & pb_oe), 32'h0c);
    chk("pb_pullup", 32'(pb_pu), 32'h30);
    chk("pb_die", 32'(pb_die), 32'hff);
    rd("pb_levels", PDO_OFS_PB_LVL, 32'h5c);
    wr(PDO_OFS_PB_LVL, 32'hff);
    rd("pb_levels_ro", PDO_OFS_PB_LVL, 32'h5c);
    rd("unmapped", 8'h30, 32'h0);
    chk("unmapped_err", 32'(last_err), 32'h1);
    wr(PDO_OFS_PD_LATCH, 32'h01);
    wr(PDO_OFS_PD_DIR, 32'hff);
    chk("pd_oe_plain", 32'(pd_oe), 32'hff);
    @(posedge pclk);
    periph <= pdo_periph_t'(13'b1_1_1_1_0_1_0_1_1_1_1_0_0);
    @(negedge pclk);
    chk("pd_oe_ovr", 32'(pd_oe), 32'hfe);
    chk("pd_pullup_ovr", 32'(pd_pu), 32'h01);
    chk("pd_drive_a", 32'(pd_out & pd_oe), 32'h2a);
    @(posedge pclk);
    periph <= pdo_periph_t'(13'b1_1_0_1_1_1_1_1_0_1_0_0_0);
    @(negedge pclk);
    chk("pd_drive_b", 32'(pd_out & pd_oe), 32'h50);
    wr(PDO_OFS_CTRL, 32'h1);
    chk("pd_pullup_pud", 32'(pd_pu), 32'h00);
    @(posedge pclk);
    sleep_active <= 1'b1;
    wr(PDO_OFS_PC_MASK, 32'hff);
    wr(PDO_OFS_CTRL, 32'h4);
    chk("pd_die_g2", 32'(pd_die), 32'hfb);
    wr(PDO_OFS_CTRL, 32'h2);
    chk("pd_die_g1", 32'(pd_die), 32'h04);
    wr(PDO_OFS_PC_MASK, 32'h00);
    @(posedge pclk);
    periph <= pdo_periph_t'(13'h3);
    @(negedge pclk);
    chk("pd_die_ext", 32'(pd_die), 32'h0c);
    @(posedge pclk);
    sleep_active <= 1'b0;
    periph <= '0;
    wr(PDO_OFS_PD_DIR, 32'h00);
    wr(PDO_OFS_PC_MASK, 32'h01);
    wr(PDO_OFS_CTRL, 32'h4);
    wr(PDO_OFS_IRQ_MASK, 32'h1);
    wr(PDO_OFS_IRQ_STAT, 32'h1);
    rd("stat_clear", PDO_OFS_IRQ_STAT, 32'h0);
    watch(8'h80);
    chk("no_pulse_unmasked", 32'(got), 32'h0);
    watch(8'h81);
    chk("pulse_src16", 32'(got), 32'h1);
    chk("src16_level", 32'(src16), 32'h1);
    chk("rx_level", 32'(rx_data), 32'h1);
    rd("stat_set", PDO_OFS_IRQ_STAT, 32'h1);
    chk("irq_on", 32'(irq), 32'h1);
    wr(PDO_OFS_IRQ_MASK, 32'h0);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(PDO_OFS_IRQ_STAT, 32'h1);
    rd("stat_w1c", PDO_OFS_IRQ_STAT, 32'h0);
    wr(PDO_OFS_CTRL, 32'h0);
    watch(8'h80);
    chk("no_pulse_disabled", 32'(got), 32'h0);
    @(posedge pclk);
    ed_en <= 8'hfe;
    rd("pd_levels_pullup", PDO_OFS_PD_LVL, 32'h81);
    complete_run();
  end
endmodule
